// ---- verilog/aeq_dev.sv ----
// filter chain device: first/separation/equaliser IIR stages and gain, placed by power state
// Operation
// - DAC only powered: chain sits in playback
// - any ADC powered: chain sits in recording
// - settings persist across path change
// - three first-order IIR stages, programmable coefficients
// - type select 0 high-pass, 1 low-pass
// - disabled equaliser or first filter pass through
// - disabled separation filter outputs silence, except under mono mix where the stage is skipped
// - software bypasses stage before rewriting coefficients
// - mono mix: only first filter usable
// - gain codes 0dB, +12dB, +24dB
// - separation emphasis acts only in stereo
// - high-pass A(1-z^-1)/(1+Bz^-1)
// - low-pass A(1+z^-1)/(1+Bz^-1)
// - equaliser (A+Cz^-1)/(1+Bz^-1)
// - coefficients two's complement scaled by 2^13
// - software keeps equaliser gain within +12dB
// - both ADCs with mix give (L+R)/2
`timescale 1ns/100ps
module aeq_dev (
    input  wire logic                              clk,
    input  wire logic                              arst_n,
    aeq_if.dev                                     lnk,
    input  wire logic                              adc_valid,
    output wire logic                              adc_ready,
    input  wire logic signed [aeq_pkg::DATA_W-1:0] adc_left,
    input  wire logic signed [aeq_pkg::DATA_W-1:0] adc_right,
    output wire logic                              dac_valid,
    input  wire logic                              dac_ready,
    output wire logic signed [aeq_pkg::DATA_W-1:0] dac_left,
    output wire logic signed [aeq_pkg::DATA_W-1:0] dac_right
);
    localparam int DW = aeq_pkg::DATA_W;
    localparam int AW = aeq_pkg::ACC_W;

    // clamp a wide accumulator to a sample
    function automatic logic signed [DW-1:0] sat(input logic signed [AW-1:0] v);
        logic signed [AW-1:0] hi;
        logic signed [AW-1:0] lo;
        hi = AW'(2 ** (DW - 1) - 1);
        lo = -AW'(2 ** (DW - 1));
        if (v > hi) begin
            sat = DW'(hi);
        end else if (v < lo) begin
            sat = DW'(lo);
        end else begin
            sat = DW'(v);
        end
    endfunction : sat

    // selectable first-order section; products are scaled back by the 2^13 point
    function automatic logic signed [DW-1:0] iir_sel(
        input logic signed [DW-1:0]                x,
        input logic signed [DW-1:0]                xp,
        input logic signed [DW-1:0]                yp,
        input logic signed [aeq_pkg::COEF_W-1:0]   a,
        input logic signed [aeq_pkg::COEF_W-1:0]   b,
        input logic                                lp
    );
        logic signed [AW-1:0] num;
        logic signed [AW-1:0] acc;
        num = (lp == aeq_pkg::TYPE_LOW_PASS) ? AW'(x) + AW'(xp)
                                              : AW'(x) - AW'(xp);
        acc = AW'(a) * num - AW'(b) * AW'(yp);
        iir_sel = sat(acc >>> aeq_pkg::COEF_FRAC);
    endfunction : iir_sel

    // equaliser section with independent zero
    function automatic logic signed [DW-1:0] iir_eq(
        input logic signed [DW-1:0]                 x,
        input logic signed [DW-1:0]                 xp,
        input logic signed [DW-1:0]                 yp,
        input logic signed [aeq_pkg::EQ_COEF_W-1:0] a,
        input logic signed [aeq_pkg::COEF_W-1:0]    b,
        input logic signed [aeq_pkg::EQ_COEF_W-1:0] c
    );
        logic signed [AW-1:0] acc;
        acc = AW'(a) * AW'(x) + AW'(c) * AW'(xp) - AW'(b) * AW'(yp);
        iir_eq = sat(acc >>> aeq_pkg::COEF_FRAC);
    endfunction : iir_eq

    // output gain block, shifts approximate the dB steps
    function automatic logic signed [DW-1:0] gain(
        input logic signed [DW-1:0] x,
        input logic [1:0]           sel
    );
        if (sel == aeq_pkg::GAIN_0DB) begin
            gain = x;
        end else if (sel == aeq_pkg::GAIN_12DB) begin
            gain = sat(AW'(x) <<< aeq_pkg::GAIN_12DB_SHIFT);
        end else begin
            gain = sat(AW'(x) <<< aeq_pkg::GAIN_24DB_SHIFT);
        end
    endfunction : gain

    aeq_pkg::aeq_cfg_s cfg;
    assign cfg = lnk.cfg;

    // placement: any ADC wins over the DAC, loopback plays no part
    wire logic path_rec  = cfg.adc_left_power | cfg.adc_right_power;
    wire logic path_play = cfg.dac_power & ~path_rec;
    assign lnk.path = path_rec  ? aeq_pkg::AEQ_PATH_REC :
                      path_play ? aeq_pkg::AEQ_PATH_PLAY : aeq_pkg::AEQ_PATH_OFF;

    // stereo only when both channels carry their own signal
    wire logic both_adc = cfg.adc_left_power & cfg.adc_right_power;
    wire logic mix_on   = path_rec & both_adc & cfg.mono_mix;
    wire logic stereo   = ~path_rec | (both_adc & ~cfg.mono_mix);

    // output holding registers, one per direction
    logic              up_v_q;
    logic              dac_v_q;
    logic signed [DW-1:0] up_q [2];
    logic signed [DW-1:0] dac_q [2];
    wire logic up_free  = ~up_v_q | lnk.up_ready;
    wire logic dac_free = ~dac_v_q | dac_ready;

    // filter source and sink follow the placement; settings are never touched here
    wire logic out_free  = path_rec ? up_free : dac_free;
    wire logic src_valid = path_rec ? adc_valid : (path_play & lnk.dn_valid);
    wire logic filt_fire = src_valid & out_free;
    // while recording, playback still reaches the DAC, unfiltered
    wire logic raw_fire  = path_rec & cfg.dac_power & lnk.dn_valid & dac_free;

    assign adc_ready    = path_rec & out_free;
    assign lnk.dn_ready = path_play ? out_free : (path_rec & cfg.dac_power & dac_free);

    // channel mapping of the converter input
    logic signed [DW:0]   mix_sum;
    logic signed [DW-1:0] src [2];
    assign mix_sum = {adc_left[DW-1], adc_left} + {adc_right[DW-1], adc_right};
    assign src[0] = !path_rec ? lnk.dn_left :
                    mix_on ? mix_sum[DW:1] :
                    (cfg.adc_left_power ? adc_left : adc_right);
    assign src[1] = !path_rec ? lnk.dn_right :
                    mix_on ? mix_sum[DW:1] :
                    (cfg.adc_right_power ? adc_right : adc_left);

    // in mono the equaliser is held off whatever software left set
    wire logic eq_use = cfg.equaliser_en & ~mix_on;

    logic signed [DW-1:0] res [2];

    // one identical chain per channel, each with its own history
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic signed [DW-1:0] f1_xp_q, f1_yp_q, sp_xp_q, sp_yp_q, eq_xp_q, eq_yp_q;
            logic signed [DW-1:0] f1_raw, f1_out, sp_raw, sp_out, eq_raw, eq_out;

            assign f1_raw = iir_sel(src[ch], f1_xp_q, f1_yp_q, cfg.first_filter_coef_a,
                                    cfg.first_filter_coef_b, cfg.first_filter_type_sel);
            assign f1_out = cfg.first_filter_en ? f1_raw : src[ch];

            assign sp_raw = iir_sel(f1_out, sp_xp_q, sp_yp_q, cfg.separation_filter_coef_a,
                                    cfg.separation_filter_coef_b,
                                    cfg.separation_filter_type_sel);
            // disabled means mute; outside stereo the emphasis has nothing to act on;
            // under mono mix the stage is skipped so the first filter stays usable
            assign sp_out = mix_on ? f1_out :
                            !cfg.separation_filter_en ? '0 :
                            (stereo ? sp_raw : f1_out);

            assign eq_raw = iir_eq(sp_out, eq_xp_q, eq_yp_q, cfg.equaliser_coef_a,
                                   cfg.equaliser_coef_b, cfg.equaliser_coef_c);
            assign eq_out = eq_use ? eq_raw : sp_out;

            assign res[ch] = gain(eq_out, cfg.gain_stage_select);

            // history moves only when a sample is taken
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    f1_xp_q <= '0;
                    f1_yp_q <= '0;
                    sp_xp_q <= '0;
                    sp_yp_q <= '0;
                    eq_xp_q <= '0;
                    eq_yp_q <= '0;
                end else if (filt_fire) begin
                    f1_xp_q <= src[ch];
                    f1_yp_q <= f1_out;
                    sp_xp_q <= f1_out;
                    sp_yp_q <= sp_out;
                    eq_xp_q <= sp_out;
                    eq_yp_q <= eq_out;
                end
            end
        end
    endgenerate

    // recorded pair toward the partner
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            up_v_q <= 1'b0;
            up_q   <= '{default: '0};
        end else if (up_free) begin
            up_v_q <= filt_fire & path_rec;
            if (filt_fire & path_rec) begin
                up_q <= res;
            end
        end
    end

    // playback pair toward the DAC: filtered in playback, raw while recording
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dac_v_q <= 1'b0;
            dac_q   <= '{default: '0};
        end else if (dac_free) begin
            dac_v_q <= (filt_fire & path_play) | raw_fire;
            if (filt_fire & path_play) begin
                dac_q <= res;
            end else if (raw_fire) begin
                dac_q <= '{lnk.dn_left, lnk.dn_right};
            end
        end
    end

    assign lnk.up_valid = up_v_q;
    assign lnk.up_left  = up_q[0];
    assign lnk.up_right = up_q[1];
    assign dac_valid    = dac_v_q;
    assign dac_left     = dac_q[0];
    assign dac_right    = dac_q[1];

endmodule : aeq_dev

// ---- verilog/aeq_pkg.sv ----
// shared constants and types for the audio filter chain and its partner
package aeq_pkg;

    localparam int DATA_W      = 16;              // audio sample width
    localparam int COEF_W      = 14;              // selectable stage and pole coefficient width
    localparam int EQ_COEF_W   = 16;              // equaliser numerator coefficient width
    localparam int COEF_FRAC   = 13;              // coefficients are real value times 2^13
    localparam int ACC_W       = 40;              // accumulator width, holds any product sum
    localparam int FIFO_DEPTH  = 16;              // words in the recorded-sample buffer
    localparam int FIFO_W      = 2 * DATA_W;      // one stereo pair per buffer word

    localparam logic [1:0] GAIN_0DB  = 2'h0;      // gain code for 0dB
    localparam logic [1:0] GAIN_12DB = 2'h1;      // gain code for +12dB, upper bit set is +24dB
    localparam int         GAIN_12DB_SHIFT = 2;   // +12dB taken as x4
    localparam int         GAIN_24DB_SHIFT = 4;   // +24dB taken as x16

    localparam logic TYPE_HIGH_PASS = 1'b0;       // type select value for high-pass
    localparam logic TYPE_LOW_PASS  = 1'b1;       // type select value for low-pass

    // where the chain currently sits
    typedef enum logic [1:0] {
        AEQ_PATH_OFF  = 2'b00,
        AEQ_PATH_PLAY = 2'b01,
        AEQ_PATH_REC  = 2'b10
    } aeq_path_e;

    // power, mode and coefficient settings as software writes them
    typedef struct packed {
        logic                        adc_left_power;
        logic                        adc_right_power;
        logic                        dac_power;
        logic                        mono_mix;
        logic                        first_filter_en;
        logic                        separation_filter_en;
        logic                        equaliser_en;
        logic                        first_filter_type_sel;
        logic                        separation_filter_type_sel;
        logic signed [COEF_W-1:0]    first_filter_coef_a;
        logic signed [COEF_W-1:0]    first_filter_coef_b;
        logic signed [COEF_W-1:0]    separation_filter_coef_a;
        logic signed [COEF_W-1:0]    separation_filter_coef_b;
        logic signed [EQ_COEF_W-1:0] equaliser_coef_a;
        logic signed [COEF_W-1:0]    equaliser_coef_b;
        logic signed [EQ_COEF_W-1:0] equaliser_coef_c;
        logic [1:0]                  gain_stage_select;
    } aeq_cfg_s;

endpackage : aeq_pkg

// ---- verilog/aeq_if.sv ----
// link between the filter chain device and its controlling partner
`timescale 1ns/100ps
interface aeq_if;
    aeq_pkg::aeq_cfg_s                 cfg;       // settings, partner to device
    aeq_pkg::aeq_path_e                path;      // chain placement, device to partner
    logic                              dn_valid;  // playback pair offered by partner
    logic                              dn_ready;
    logic signed [aeq_pkg::DATA_W-1:0] dn_left;
    logic signed [aeq_pkg::DATA_W-1:0] dn_right;
    logic                              up_valid;  // recorded pair offered by device
    logic                              up_ready;
    logic signed [aeq_pkg::DATA_W-1:0] up_left;
    logic signed [aeq_pkg::DATA_W-1:0] up_right;

    modport dev  (input cfg, dn_valid, dn_left, dn_right, up_ready,
                  output path, dn_ready, up_valid, up_left, up_right);
    modport host (output cfg, dn_valid, dn_left, dn_right, up_ready,
                  input path, dn_ready, up_valid, up_left, up_right);
endinterface : aeq_if

// ---- verilog/aeq_host.sv ----
// partner end: settings sequencer, playback source and buffered recorded-sample sink
`timescale 1ns/100ps
module aeq_fifo #(
    parameter int WIDTH = aeq_pkg::FIFO_W,
    parameter int DEPTH = aeq_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    output wire logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output wire logic             out_valid,
    input  wire logic             out_ready,
    output wire logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;

    // extra pointer bit tells full from empty
    wire logic empty = (wr_q == rd_q);
    wire logic full  = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
    wire logic push  = in_valid & ~full;
    wire logic pop   = out_ready & ~empty;
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule : aeq_fifo

module aeq_host (
    input  wire logic                              clk,
    input  wire logic                              arst_n,
    aeq_if.host                                    lnk,
    input  wire logic                              cfg_we,
    input  wire aeq_pkg::aeq_cfg_s                 cfg_wdata,
    output wire logic                              cfg_busy,
    input  wire logic                              play_bypass,
    output wire aeq_pkg::aeq_path_e                path,
    input  wire logic                              pb_valid,
    output wire logic                              pb_ready,
    input  wire logic signed [aeq_pkg::DATA_W-1:0] pb_left,
    input  wire logic signed [aeq_pkg::DATA_W-1:0] pb_right,
    output wire logic                              rec_valid,
    input  wire logic                              rec_ready,
    output wire logic signed [aeq_pkg::DATA_W-1:0] rec_left,
    output wire logic signed [aeq_pkg::DATA_W-1:0] rec_right
);
    localparam int DW = aeq_pkg::DATA_W;

    typedef enum logic [1:0] {
        AEQ_ST_IDLE   = 2'b00,
        AEQ_ST_BYPASS = 2'b01,
        AEQ_ST_LOAD   = 2'b10
    } aeq_state_e;

    aeq_state_e        state_q;
    aeq_pkg::aeq_cfg_s cur_q;
    aeq_pkg::aeq_cfg_s pend_q;
    aeq_pkg::aeq_cfg_s masked;
    aeq_pkg::aeq_cfg_s pend_off;
    logic [2:0]        chg_q;   // first, separation, equaliser coefficients changed

    // which stages get new coefficients
    wire logic [2:0] chg = {
        (cfg_wdata.equaliser_coef_a != cur_q.equaliser_coef_a) |
        (cfg_wdata.equaliser_coef_b != cur_q.equaliser_coef_b) |
        (cfg_wdata.equaliser_coef_c != cur_q.equaliser_coef_c),
        (cfg_wdata.separation_filter_coef_a != cur_q.separation_filter_coef_a) |
        (cfg_wdata.separation_filter_coef_b != cur_q.separation_filter_coef_b),
        (cfg_wdata.first_filter_coef_a != cur_q.first_filter_coef_a) |
        (cfg_wdata.first_filter_coef_b != cur_q.first_filter_coef_b)};

    // pending settings with the changing stages still held in bypass or mute
    always_comb begin
        pend_off = pend_q;
        pend_off.first_filter_en      = pend_q.first_filter_en & ~chg_q[0];
        pend_off.separation_filter_en = pend_q.separation_filter_en & ~chg_q[1];
        pend_off.equaliser_en         = pend_q.equaliser_en & ~chg_q[2];
    end

    // a write takes three steps so no stage runs on half-written coefficients
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= AEQ_ST_IDLE;
            cur_q   <= '0;
            pend_q  <= '0;
            chg_q   <= '0;
        end else begin
            case (state_q)
                AEQ_ST_IDLE: begin
                    if (cfg_we) begin
                        pend_q  <= cfg_wdata;
                        chg_q   <= chg;
                        cur_q.first_filter_en      <= cur_q.first_filter_en & ~chg[0];
                        cur_q.separation_filter_en <= cur_q.separation_filter_en & ~chg[1];
                        cur_q.equaliser_en         <= cur_q.equaliser_en & ~chg[2];
                        state_q <= AEQ_ST_BYPASS;
                    end
                end
                AEQ_ST_BYPASS: begin
                    cur_q   <= pend_off;
                    state_q <= AEQ_ST_LOAD;
                end
                AEQ_ST_LOAD: begin
                    cur_q   <= pend_q;
                    state_q <= AEQ_ST_IDLE;
                end
                default: begin
                    state_q <= AEQ_ST_IDLE;
                end
            endcase
        end
    end
    assign cfg_busy = (state_q != AEQ_ST_IDLE);

    // playback placement from own settings; reading the link path here would form a loop
    wire logic play_now = cur_q.dac_power & ~(cur_q.adc_left_power | cur_q.adc_right_power);

    // mono keeps equaliser and separation off; optional clear on playback
    always_comb begin
        masked = cur_q;
        if (cur_q.mono_mix) begin
            masked.equaliser_en         = 1'b0;
            masked.separation_filter_en = 1'b0;
        end
        if (play_bypass && play_now) begin
            masked.first_filter_en      = 1'b0;
            masked.separation_filter_en = 1'b0;
            masked.equaliser_en         = 1'b0;
            masked.gain_stage_select    = aeq_pkg::GAIN_0DB;
        end
    end
    assign lnk.cfg = masked;
    assign path    = lnk.path;

    // playback pair held in a register toward the device
    logic              dn_v_q;
    logic [2*DW-1:0]   dn_q;
    wire logic dn_free = ~dn_v_q | lnk.dn_ready;
    assign pb_ready = dn_free;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dn_v_q <= 1'b0;
            dn_q   <= '0;
        end else if (dn_free) begin
            dn_v_q <= pb_valid;
            if (pb_valid) begin
                dn_q <= {pb_left, pb_right};
            end
        end
    end
    assign lnk.dn_valid = dn_v_q;
    assign lnk.dn_left  = dn_q[2*DW-1:DW];
    assign lnk.dn_right = dn_q[DW-1:0];

    // recorded pairs buffered; a full buffer stalls the device chain
    logic [2*DW-1:0] rec_data;
    aeq_fifo #(.WIDTH(aeq_pkg::FIFO_W), .DEPTH(aeq_pkg::FIFO_DEPTH)) aeq_fifo_i (
        .clk      (clk),
        .arst_n   (arst_n),
        .in_valid (lnk.up_valid),
        .in_ready (lnk.up_ready),
        .in_data  ({lnk.up_left, lnk.up_right}),
        .out_valid(rec_valid),
        .out_ready(rec_ready),
        .out_data (rec_data)
    );
    assign rec_left  = rec_data[2*DW-1:DW];
    assign rec_right = rec_data[DW-1:0];

endmodule : aeq_host

// ---- tb/aeq_assertions.sv ----
// link-side checks for the filter chain placement, handshake and settings order
`timescale 1ns/100ps
module aeq_assertions (
    input wire logic                              clk,
    input wire logic                              arst_n,
    input wire aeq_pkg::aeq_cfg_s                 cfg,
    input wire aeq_pkg::aeq_path_e                path,
    input wire logic                              dn_ready,
    input wire logic                              up_valid,
    input wire logic                              up_ready,
    input wire logic signed [aeq_pkg::DATA_W-1:0] up_left,
    input wire logic signed [aeq_pkg::DATA_W-1:0] up_right
);
    // helpers keep the sampled functions on plain signals
    wire adc_on  = cfg.adc_left_power | cfg.adc_right_power;
    wire up_free = !up_valid | up_ready;
    wire sep_off = !cfg.separation_filter_en;
    // mono mix skips the separation stage, so its enable mutes only outside mix
    wire mix_on   = cfg.mono_mix & cfg.adc_left_power & cfg.adc_right_power;
    wire sep_mute = sep_off & !mix_on;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_PATH_PLAY: assert property (
        !adc_on && cfg.dac_power |-> path == aeq_pkg::AEQ_PATH_PLAY)
        else $error("chain not in playback");
    AST_PATH_REC: assert property (adc_on |-> path == aeq_pkg::AEQ_PATH_REC)
        else $error("chain not in recording");
    AST_OFF_REFUSE: assert property (path == aeq_pkg::AEQ_PATH_OFF |-> !dn_ready)
        else $error("playback taken while off");
    AST_UP_HOLD: assert property (
        up_valid && !up_ready |=> up_valid && $stable(up_left) && $stable(up_right))
        else $error("recorded pair dropped");
    AST_UP_FROM_REC: assert property (
        $rose(up_valid) |-> $past(path) == aeq_pkg::AEQ_PATH_REC)
        else $error("recorded pair outside recording");
    AST_MIX_MASK: assert property (cfg.mono_mix |-> !cfg.equaliser_en && sep_off)
        else $error("stage enabled under mix");
    AST_SEP_MUTE: assert property (up_valid && $past(up_free) && $past(sep_mute)
        |-> up_left == 16'h0 && up_right == 16'h0) else $error("separation not muted");
    AST_COEF_SAFE: assert property ($changed(cfg.first_filter_coef_a)
        |-> !cfg.first_filter_en && !$past(cfg.first_filter_en)) else $error("coef live");
endmodule : aeq_assertions

// ---- tb/audio_eq_hpf_lpf_chain_tb.sv ----
// bench: host end and device end joined by the link, driven from both user sides
`timescale 1ns/100ps
module audio_eq_hpf_lpf_chain_tb;
    logic clk = 1'h0, arst_n = 1'h0, adc_valid = 1'h0, cfg_we = 1'h0;
    logic pb_valid = 1'h0, rec_ready = 1'h0, play_bypass = 1'h0;
    logic signed [15:0] adc_l = 16'h0, adc_r = 16'h0;
    logic [15:0] e;
    aeq_pkg::aeq_cfg_s c = '0;
    wire logic adc_ready, dac_valid, cfg_busy, pb_ready, rec_valid;
    wire logic signed [15:0] dac_l, dac_r, rec_l, rec_r;
    wire aeq_pkg::aeq_path_e path;
    int failures = 0, compares = 0, k, n;
    aeq_if aeq_if_i ();
    aeq_dev aeq_dev_i (.clk(clk), .arst_n(arst_n), .lnk(aeq_if_i.dev), .adc_valid(adc_valid),
        .adc_ready(adc_ready), .adc_left(adc_l), .adc_right(adc_r), .dac_valid(dac_valid),
        .dac_ready(1'h1), .dac_left(dac_l), .dac_right(dac_r));
    aeq_host aeq_host_i (.clk(clk), .arst_n(arst_n), .lnk(aeq_if_i.host), .cfg_we(cfg_we),
        .cfg_wdata(c), .cfg_busy(cfg_busy), .play_bypass(play_bypass), .path(path),
        .pb_valid(pb_valid), .pb_ready(pb_ready), .pb_left(adc_l), .pb_right(adc_r),
        .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_left(rec_l), .rec_right(rec_r));
    aeq_assertions aeq_assertions_i (.clk(clk), .arst_n(arst_n), .cfg(aeq_if_i.cfg),
        .path(aeq_if_i.path), .dn_ready(aeq_if_i.dn_ready), .up_valid(aeq_if_i.up_valid),
        .up_ready(aeq_if_i.up_ready), .up_left(aeq_if_i.up_left),
        .up_right(aeq_if_i.up_right));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic hang;
        failures++;
        test_done();
    endtask : hang
    // settings go as one whole struct; wait out the busy window before the next write
    task automatic cfg_write;
        @(negedge clk) cfg_we = 1'h1;
        @(negedge clk) cfg_we = 1'h0;
        for (k = 0; k < 9 && cfg_busy; k++) @(negedge clk);
        if (cfg_busy) hang();
    endtask : cfg_write
    // offers one pair; a refused pair is withdrawn after the given tries
    task automatic send(input logic [15:0] l, input int tries);
        @(negedge clk) adc_valid = 1'h1;
        adc_l = l;
        adc_r = 16'h0567;
        for (k = 0; k < tries && !adc_ready; k++) @(negedge clk);
        n = n + int'(adc_ready);
        @(negedge clk) adc_valid = 1'h0;
    endtask : send
    task automatic recv(input logic [15:0] el, input logic [15:0] er);
        @(negedge clk);
        for (k = 0; k < 50 && !rec_valid; k++) @(negedge clk);
        if (!rec_valid) hang();
        chk(rec_l, el);
        chk(rec_r, er);
        rec_ready = 1'h1;
        @(negedge clk) rec_ready = 1'h0;
    endtask : recv
    initial begin
        repeat (4) @(negedge clk);
        arst_n = 1'h1;
        chk(16'(path), 16'(aeq_pkg::AEQ_PATH_OFF));
        c.adc_left_power = 1'h1;
        c.separation_filter_en = 1'h1;
        cfg_write();
        chk(16'(path), 16'(aeq_pkg::AEQ_PATH_REC));
        // single left converter feeds both channels; each gain code in turn
        for (int g = 0; g < 4; g++) begin
            c.gain_stage_select = 2'(g);
            cfg_write();
            send(16'h0010, 50);
            e = (g == 0) ? 16'h0010 : (g == 1) ? 16'h0040 : 16'h0100;
            recv(e, e);
        end
        c.gain_stage_select = 2'h0;
        c.first_filter_en = 1'h1;
        c.first_filter_coef_a = 14'h1000;
        cfg_write();
        send(16'h0100, 50);
        recv(16'h0078, 16'h0078);
        send(16'h0100, 50);
        recv(16'h0000, 16'h0000);
        c.first_filter_type_sel = aeq_pkg::TYPE_LOW_PASS;
        cfg_write();
        send(16'h0100, 50);
        recv(16'h0100, 16'h0100);
        c.first_filter_en = 1'h0;
        c.equaliser_en = 1'h1;
        c.equaliser_coef_a = 16'h2000;
        c.equaliser_coef_c = 16'hF000;
        cfg_write();
        send(16'h0100, 50);
        recv(16'h0080, 16'h0080);
        c.equaliser_en = 1'h0;
        c.adc_right_power = 1'h1;
        c.separation_filter_en = 1'h0;
        cfg_write();
        send(16'h1234, 50);
        recv(16'h0000, 16'h0000);
        // stereo separation low-pass at a quarter, each channel on its own history
        c.separation_filter_en = 1'h1;
        c.separation_filter_type_sel = aeq_pkg::TYPE_LOW_PASS;
        c.separation_filter_coef_a = 14'h0800;
        cfg_write();
        send(16'h1234, 50);
        recv(16'h091A, 16'h02B3);
        // mono mix: separation skipped, both channels carry the average
        c.mono_mix = 1'h1;
        cfg_write();
        send(16'h1234, 50);
        recv(16'h0BCD, 16'h0BCD);
        // fill the buffer with the sink stalled, then drain it in order
        c.mono_mix = 1'h0;
        c.adc_right_power = 1'h0;
        cfg_write();
        n = 0;
        for (int i = 0; i < 20; i++) send(16'(i), 3);
        chk(16'(n), 16'h0011);
        for (int i = 0; i < 17; i++) recv(16'(i), 16'(i));
        c.adc_left_power = 1'h0;
        c.dac_power = 1'h1;
        play_bypass = 1'h1;
        cfg_write();
        chk(16'(path), 16'(aeq_pkg::AEQ_PATH_PLAY));
        @(negedge clk) pb_valid = 1'h1;
        for (k = 0; k < 50 && !pb_ready; k++) @(negedge clk);
        if (!pb_ready) hang();
        @(negedge clk) pb_valid = 1'h0;
        for (k = 0; k < 50 && !dac_valid; k++) @(negedge clk);
        if (!dac_valid) hang();
        chk(dac_l, 16'h0000);
        chk(dac_r, 16'h0000);
        test_done();
    end
endmodule : audio_eq_hpf_lpf_chain_tb
